// ### core/dspc_core.v
// DSP core datapath: fetch, working registers, X/Y address generators, DSP engine.
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/100ps
`include "dspc_consts.vh"
module dspc_core (
    // Clock and reset.
    input wire clock,
    input wire reset,
    // APB register port.
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Program memory, read data valid in the cycle its address is shown.
    output reg [22:0] prog_addr,
    input wire [23:0] prog_rdata,
    // X data memory, read and write.
    output reg [15:0] x_addr,
    output reg x_rd,
    output reg x_wr,
    output reg [15:0] x_wdata,
    input wire [15:0] x_rdata,
    // Y data memory, read only.
    output reg [15:0] y_addr,
    output reg y_rd,
    input wire [15:0] y_rdata,
    // Interrupt requests and current priority level.
    input wire [3:0] irq,
    output reg [3:0] cpu_ipl
);

localparam S_RUN = 3'h0;
localparam S_PH2 = 3'h1;
localparam S_TBL = 3'h2;
localparam S_INT = 3'h3;
localparam S_RET = 3'h4;
localparam S_RET2 = 3'h5;

reg [15:0] w_r [0:15];
reg [23:0] ir_r;
reg irv_r;
reg [22:0] irpc_r;
reg [2:0] st_r;
reg [39:0] acca_r;
reg [39:0] accb_r;
reg [15:0] trap_r;
reg [15:0] interrupt_priority_control_0_r;
reg [15:0] ctrl_r;
reg [15:0] xms_r;
reg [15:0] xme_r;
reg [15:0] yms_r;
reg [15:0] yme_r;
reg [7:0] page_r;
reg [22:0] save_r;
reg [3:0] tbl_rd_r;
reg wbx_r;
reg wby_r;
reg [3:0] wbxd_r;
reg [3:0] wbyd_r;
reg [13:0] rep_r;
reg [22:0] repa_r;
reg [15:0] do_cnt_r;
reg [22:0] do_st_r;
reg [22:0] do_end_r;
reg [15:0] tmp_r;
reg trap_pend_r;
reg [3:0] irq_m_r;
reg [3:0] irq_s_r;
integer k;
integer m;

// A load still in flight is forwarded, so back-to-back use needs no stall.
function [15:0] rf;
    input [3:0] i;
    begin
        if (wbx_r && wbxd_r == i)
            rf = x_rdata;
        else if (wby_r && wbyd_r == i)
            rf = y_rdata;
        else
            rf = w_r[i];
    end
endfunction

// Post-modify of an address pointer. Bit reversal covers 16 entries only.
function [15:0] address_generator;
    input [15:0] ea;
    input [1:0] m;
    input [15:0] lo;
    input [15:0] hi;
    reg [3:0] a;
    reg [3:0] b;
    integer j;
    begin
        a = ea[`F_BRV];
        for (j = 0; j < `BRV_N; j = j + 1)
            b[j] = a[`BRV_N - 1 - j];
        b = b + 4'h1;
        for (j = 0; j < `BRV_N; j = j + 1)
            a[j] = b[`BRV_N - 1 - j];
        case (m)
            `M_MOD: address_generator = (ea == hi) ? lo : ea + `STEP;
            `M_REV: address_generator = {ea[`F_BRH], a, ea[`F_B0]};
            default: address_generator = ea + `STEP;
        endcase
    end
endfunction

wire [3:0] op = ir_r[`F_OP];
wire [3:0] rd = ir_r[`F_RD];
wire [3:0] rs = ir_r[`F_RS];
wire [3:0] rt = ir_r[`F_RT];
wire [1:0] md = ir_r[`F_MD];
wire [15:0] imm = ir_r[`F_IMM];
wire asel = ir_r[`F_ASEL];
wire sat = ir_r[`F_SAT];
wire [5:0] sh = ir_r[`F_SH];
wire run = ctrl_r[`C_RUN];
wire [15:0] vs = rf(rs);
wire [15:0] vt = rf(rt);
wire [15:0] vd = rf(rd);
wire [15:0] vma = rf(`W_MA);
wire [15:0] vmb = rf(`W_MB);
wire [15:0] vsp = rf(`W_SP);
wire [15:0] vyp = rf(`W_YP);
wire [15:0] xea = (op == `OP_MAC) ? rf(`W_XP) : vs;
wire [15:0] xnx = address_generator(xea, md, xms_r, xme_r);
wire [1:0] ymd = ctrl_r[`C_YMOD] ? `M_MOD : `M_LIN;
wire [15:0] ynx = address_generator(vyp, ymd, yms_r, yme_r);
wire psv = ctrl_r[`C_PSV] & xea[`F_PSV];
wire [22:0] psv_a = {1'h0, page_r, xea[`F_PSVO]};
wire [22:0] rel = {{7{imm[15]}}, imm};

// DSP engine.
wire [39:0] acc = asel ? accb_r : acca_r;
wire signed [33:0] prod = $signed({vma[15], vma}) * $signed({vmb[15], vmb});
wire [40:0] sum = {acc[39], acc} + {{7{prod[33]}}, prod};
wire cat = sum[40] ^ sum[39];
wire ov = ~(&sum[39:31]) & (|sum[39:31]);
wire [39:0] macv = (sat & ov) ? (sum[40] ? `SAT_N : `SAT_P) : sum[39:0];
wire bad = ~sh[5] & (sh > `SFT_MAX) | sh[5] & (sh < `SFT_MIN);
wire [5:0] nsh = 6'h00 - sh;
wire [39:0] shl = acc << nsh;
wire [39:0] shr = $signed(acc) >>> sh;
wire [39:0] shv = sh[5] ? shl : shr;

// Interrupt selection.
reg [2:0] best;
reg [1:0] bsrc;
always @* begin
    best = 3'h0;
    bsrc = 2'h0;
    for (k = 0; k < `N_IRQ; k = k + 1) begin
        if (irq_s_r[k] && interrupt_priority_control_0_r[k * `IP_STRIDE +: `IP_W] > best) begin
            best = interrupt_priority_control_0_r[k * `IP_STRIDE +: `IP_W];
            bsrc = k[1:0];
        end
    end
end

wire tsel = trap_pend_r & (cpu_ipl < `IPL_TRAP);
wire nest_ok = ~(trap_r[`T_NEST] & (cpu_ipl != 4'h0));
wire take = run & (st_r == S_RUN) & irv_r & (tsel | (({1'h0, best} > cpu_ipl) & nest_ok));
wire [3:0] lvl = tsel ? `IPL_TRAP : {1'h0, best};
wire [22:0] vec = tsel ? `V_TRAP : `V_IRQ + {20'h0_0000, bsrc, 1'h0};
wire ex = run & (st_r == S_RUN) & irv_r & ~take;
wire rep_hold = irv_r & (rep_r != 14'h0000) & (irpc_r == repa_r);
wire holdop = rep_hold | (op == `OP_BRA) | (op == `OP_MOVD) | (op == `OP_TBL)
    | (op == `OP_RETI) | (op == `OP_LDX & psv);
wire fgo = run & (((st_r == S_RUN) & ~take & ~(irv_r & holdop)) | (st_r == S_PH2));
wire dojmp = (do_cnt_r != 16'h0000) & (prog_addr == do_end_r);
wire [22:0] fnx = dojmp ? do_st_r : prog_addr + 23'h00_0001;
wire accw = ex & ((op == `OP_MAC) | (op == `OP_SFT & ~bad) | (op == `OP_LAC));
wire [39:0] accv = (op == `OP_MAC) ? macv :
    (op == `OP_SFT) ? shv : {{8{vs[15]}}, vs, 16'h0000};

// Trap events.
reg [15:0] ev;
always @* begin
    ev = 16'h0000;
    if (ex && op == `OP_MAC) begin
        ev[`T_OVA] = ~asel & ov & trap_r[`T_OVATE];
        ev[`T_OVB] = asel & ov & trap_r[`T_OVBTE];
        ev[`T_COVA] = ~asel & cat & trap_r[`T_COVTE];
        ev[`T_COVB] = asel & cat & trap_r[`T_COVTE];
    end
    if (ex && op == `OP_SFT && bad) begin
        ev[`T_SFT] = 1'h1;
        ev[`T_MATH] = 1'h1;
    end
    if (ex && op == `OP_DIV && vt == 16'h0000) begin
        ev[`T_DIV0] = 1'h1;
        ev[`T_MATH] = 1'h1;
    end
end

// APB decode.
wire apw = psel & penable & pready & pwrite;
wire [15:0] tw = (apw && paddr == `A_TRAP) ? pwdata[15:0] : trap_r;
reg [31:0] rdv;
reg rerr;
always @* begin
    rerr = 1'h0;
    case (paddr)
        `A_TRAP: rdv = {16'h0000, trap_r};
        `A_INTERRUPT_PRIORITY_CONTROL_0: rdv = {16'h0000, interrupt_priority_control_0_r};
        `A_PAGE: rdv = {24'h00_0000, page_r};
        `A_CTRL: rdv = {16'h0000, ctrl_r};
        `A_XMS: rdv = {16'h0000, xms_r};
        `A_XME: rdv = {16'h0000, xme_r};
        `A_YMS: rdv = {16'h0000, yms_r};
        `A_YME: rdv = {16'h0000, yme_r};
        `A_STAT: rdv = {9'h000, prog_addr};
        default: begin
            rdv = 32'h0000_0000;
            rerr = 1'h1;
        end
    endcase
end

always @(posedge clock or posedge reset) begin
    if (reset) begin
        for (m = 0; m < 16; m = m + 1)
            w_r[m] <= 16'h0000;
        w_r[`W_SP] <= `R_SP;
        ir_r <= 24'h00_0000;
        irv_r <= 1'h0;
        irpc_r <= `R_PC;
        st_r <= S_RUN;
        acca_r <= 40'h00_0000_0000;
        accb_r <= 40'h00_0000_0000;
        trap_r <= 16'h0000;
        interrupt_priority_control_0_r <= `R_INTERRUPT_PRIORITY_CONTROL_0;
        ctrl_r <= 16'h0000;
        xms_r <= 16'h0000;
        xme_r <= 16'h0000;
        yms_r <= 16'h0000;
        yme_r <= 16'h0000;
        page_r <= 8'h00;
        save_r <= `R_PC;
        tbl_rd_r <= 4'h0;
        wbx_r <= 1'h0;
        wby_r <= 1'h0;
        wbxd_r <= 4'h0;
        wbyd_r <= 4'h0;
        rep_r <= 14'h0000;
        repa_r <= `R_PC;
        do_cnt_r <= 16'h0000;
        do_st_r <= `R_PC;
        do_end_r <= `R_PC;
        tmp_r <= 16'h0000;
        trap_pend_r <= 1'h0;
        irq_m_r <= 4'h0;
        irq_s_r <= 4'h0;
        prdata <= 32'h0000_0000;
        pready <= 1'h0;
        pslverr <= 1'h0;
        prog_addr <= `R_PC;
        x_addr <= 16'h0000;
        x_rd <= 1'h0;
        x_wr <= 1'h0;
        x_wdata <= 16'h0000;
        y_addr <= 16'h0000;
        y_rd <= 1'h0;
        cpu_ipl <= 4'h0;
    end else begin
        irq_m_r <= irq;
        irq_s_r <= irq_m_r;
        pready <= psel & ~penable & ~pready;
        if (psel && !penable) begin
            prdata <= rdv;
            pslverr <= rerr;
        end
        if (apw) begin
            case (paddr)
                // The gap bit above each priority field is not implemented.
                `A_INTERRUPT_PRIORITY_CONTROL_0: interrupt_priority_control_0_r <= pwdata[15:0] & `IP_MASK;
                `A_PAGE: page_r <= pwdata[7:0];
                `A_CTRL: ctrl_r <= pwdata[15:0];
                `A_XMS: xms_r <= pwdata[15:0];
                `A_XME: xme_r <= pwdata[15:0];
                `A_YMS: yms_r <= pwdata[15:0];
                `A_YME: yme_r <= pwdata[15:0];
                default: ;
            endcase
        end
        // A new event outranks a software clear in the same cycle.
        trap_r <= (tw & `T_CTLM) | (trap_r & tw & `T_FLGM) | ev;
        if (|ev)
            trap_pend_r <= 1'h1;
        x_rd <= 1'h0;
        x_wr <= 1'h0;
        y_rd <= 1'h0;
        wbx_r <= 1'h0;
        wby_r <= 1'h0;
        if (wbx_r)
            w_r[wbxd_r] <= x_rdata;
        if (wby_r)
            w_r[wbyd_r] <= y_rdata;
        if (accw && !asel)
            acca_r <= accv;
        if (accw && asel)
            accb_r <= accv;
        if (fgo) begin
            ir_r <= prog_rdata;
            irv_r <= 1'h1;
            irpc_r <= prog_addr;
            prog_addr <= fnx;
            st_r <= S_RUN;
            if (dojmp)
                do_cnt_r <= do_cnt_r - 16'h0001;
        end
        if (ex && rep_hold)
            rep_r <= rep_r - 14'h0001;
        // Entry pushes the level and upper PC first, lower PC next cycle.
        if (take) begin
            x_addr <= vsp;
            x_wr <= 1'h1;
            x_wdata <= {cpu_ipl, 5'h00, irpc_r[`F_PCHI]};
            w_r[`W_SP] <= vsp + `STEP;
            prog_addr <= vec;
            cpu_ipl <= lvl;
            if (tsel)
                trap_pend_r <= |ev;
            st_r <= S_INT;
        end
        case (st_r)
            S_INT: begin
                x_addr <= vsp;
                x_wr <= 1'h1;
                x_wdata <= irpc_r[`F_PCLO];
                w_r[`W_SP] <= vsp + `STEP;
                ir_r <= prog_rdata;
                irpc_r <= prog_addr;
                prog_addr <= prog_addr + 23'h00_0001;
                st_r <= S_RUN;
            end
            S_PH2: begin
                x_addr <= tmp_r;
                x_rd <= 1'h1;
                wbx_r <= 1'h1;
                wbxd_r <= rd + 4'h1;
            end
            S_TBL: begin
                w_r[tbl_rd_r] <= prog_rdata[`F_PCLO];
                prog_addr <= save_r;
                irv_r <= 1'h0;
                st_r <= S_RUN;
            end
            S_RET: begin
                tmp_r <= x_rdata;
                x_addr <= vsp - `STEP;
                x_rd <= 1'h1;
                w_r[`W_SP] <= vsp - `STEP;
                st_r <= S_RET2;
            end
            S_RET2: begin
                prog_addr <= {x_rdata[`F_PCH], tmp_r};
                cpu_ipl <= x_rdata[`F_IPL];
                st_r <= S_RUN;
            end
            default: ;
        endcase
        if (ex) begin
            case (op)
                `OP_ADD: w_r[rd] <= vs + vt;
                `OP_LIT: w_r[rd] <= imm;
                `OP_LDX: begin
                    w_r[rs] <= xnx;
                    if (psv) begin
                        prog_addr <= psv_a;
                        save_r <= prog_addr;
                        tbl_rd_r <= rd;
                        irv_r <= 1'h0;
                        st_r <= S_TBL;
                    end else begin
                        x_addr <= xea;
                        x_rd <= 1'h1;
                        wbx_r <= 1'h1;
                        wbxd_r <= rd;
                    end
                end
                `OP_STX: begin
                    w_r[rs] <= xnx;
                    x_addr <= xea;
                    x_wr <= ~psv;
                    x_wdata <= vt;
                end
                `OP_MAC: begin
                    x_addr <= xea;
                    x_rd <= 1'h1;
                    wbx_r <= 1'h1;
                    wbxd_r <= `W_MA;
                    w_r[`W_XP] <= xnx;
                    y_addr <= vyp;
                    y_rd <= 1'h1;
                    wby_r <= 1'h1;
                    wbyd_r <= `W_MB;
                    w_r[`W_YP] <= ynx;
                end
                `OP_DIV: begin
                    if (vt != 16'h0000)
                        w_r[rd] <= vs / vt;
                end
                `OP_BRA: begin
                    prog_addr <= irpc_r + rel;
                    irv_r <= 1'h0;
                end
                `OP_MOVD: begin
                    x_addr <= vs;
                    x_rd <= 1'h1;
                    wbx_r <= 1'h1;
                    wbxd_r <= rd;
                    tmp_r <= vs + `STEP;
                    st_r <= S_PH2;
                end
                `OP_TBL: begin
                    prog_addr <= {vt[`F_TBLH], vs};
                    save_r <= prog_addr;
                    tbl_rd_r <= rd;
                    irv_r <= 1'h0;
                    st_r <= S_TBL;
                end
                `OP_DO: begin
                    do_cnt_r <= vd;
                    do_st_r <= irpc_r + 23'h00_0001;
                    do_end_r <= irpc_r + rel;
                end
                `OP_REP: begin
                    rep_r <= ir_r[`F_REPN];
                    repa_r <= prog_addr;
                end
                `OP_RETI: begin
                    x_addr <= vsp - `STEP;
                    x_rd <= 1'h1;
                    w_r[`W_SP] <= vsp - `STEP;
                    irv_r <= 1'h0;
                    st_r <= S_RET;
                end
                `OP_SAC: w_r[rd] <= acc[`F_ACCH];
                default: ;
            endcase
        end
    end
end

endmodule

// ### shared/dspc_consts.vh
// Constants shared by the DSP core datapath.
`ifndef DSPC_CONSTS_VH
`define DSPC_CONSTS_VH
// APB byte offsets.
`define A_TRAP 8'h00
`define A_INTERRUPT_PRIORITY_CONTROL_0 8'h04
`define A_PAGE 8'h08
`define A_CTRL 8'h0C
`define A_XMS 8'h10
`define A_XME 8'h14
`define A_YMS 8'h18
`define A_YME 8'h1C
`define A_STAT 8'h20
// Reset values.
`define R_INTERRUPT_PRIORITY_CONTROL_0 16'h4444
`define R_SP 16'h0800
`define R_PC 23'h00_0000
// Trap and nesting control fields.
`define T_NEST 15
`define T_OVA 14
`define T_OVB 13
`define T_COVA 12
`define T_COVB 11
`define T_OVATE 10
`define T_OVBTE 9
`define T_COVTE 8
`define T_SFT 7
`define T_DIV0 6
`define T_MATH 4
`define T_CTLM 16'h8700
`define T_FLGM 16'h78D0
// Core control fields.
`define C_RUN 0
`define C_PSV 1
`define C_YMOD 2
// Priority fields, one per source.
`define IP_STRIDE 4
`define IP_W 3
`define IP_MASK 16'h7777
`define N_IRQ 4
// Instruction fields.
`define F_OP 23:20
`define F_RD 19:16
`define F_RS 15:12
`define F_RT 11:8
`define F_MD 7:6
`define F_IMM 15:0
`define F_REPN 13:0
`define F_SH 5:0
`define F_ASEL 0
`define F_SAT 1
`define F_TBLH 6:0
`define F_ACCH 31:16
`define F_PSV 15
`define F_PSVO 14:1
`define F_BRV 4:1
`define F_BRH 15:5
`define F_B0 0
`define BRV_N 4
`define F_IPL 15:12
`define F_PCH 6:0
`define F_PCHI 22:16
`define F_PCLO 15:0
// Opcodes.
`define OP_NOP 4'h0
`define OP_ADD 4'h1
`define OP_LIT 4'h2
`define OP_LDX 4'h3
`define OP_STX 4'h4
`define OP_MAC 4'h5
`define OP_SFT 4'h6
`define OP_DIV 4'h7
`define OP_BRA 4'h8
`define OP_MOVD 4'h9
`define OP_TBL 4'hA
`define OP_DO 4'hB
`define OP_REP 4'hC
`define OP_RETI 4'hD
`define OP_SAC 4'hE
`define OP_LAC 4'hF
// Address generator modes.
`define M_LIN 2'h0
`define M_MOD 2'h1
`define M_REV 2'h2
// Dedicated working registers.
`define W_SP 4'hF
`define W_MA 4'h4
`define W_MB 4'h5
`define W_XP 4'h8
`define W_YP 4'hA
// Vectors, levels and limits.
`define V_TRAP 23'h00_0002
`define V_IRQ 23'h00_0004
`define IPL_TRAP 4'h8
`define STEP 16'h0002
`define SFT_MAX 6'h10
`define SFT_MIN 6'h30
`define SAT_P 40'h00_7FFF_FFFF
`define SAT_N 40'hFF_8000_0000
`endif

// ### verification/dspc_core_sva.sv
// Concurrent checks on the ports of the DSP core datapath.
`timescale 1ns/100ps
`include "dspc_consts.vh"
module dspc_core_sva (
    // Clock and reset.
    input wire clock,
    input wire reset,
    // APB register port.
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // Memories and interrupts.
    input wire [22:0] prog_addr,
    input wire [23:0] prog_rdata,
    input wire [15:0] x_addr,
    input wire x_rd,
    input wire x_wr,
    input wire [15:0] x_wdata,
    input wire [15:0] x_rdata,
    input wire [15:0] y_addr,
    input wire y_rd,
    input wire [15:0] y_rdata,
    input wire [3:0] irq,
    input wire [3:0] cpu_ipl
);
    reg run_seen_r;
    reg [15:0] ipc_r;
    wire wr_done = psel && penable && pready && pwrite;
    wire rd_done = psel && penable && pready && !pwrite;
    // Shadow of the priority register, so read-back is tied to the last write.
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            run_seen_r <= 1'b0;
            ipc_r <= `R_INTERRUPT_PRIORITY_CONTROL_0;
        end else begin
            if (wr_done && paddr == `A_CTRL && pwdata[0])
                run_seen_r <= 1'b1;
            if (wr_done && paddr == `A_INTERRUPT_PRIORITY_CONTROL_0)
                ipc_r <= pwdata[15:0] & 16'h7777;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    AST_PREADY_ONE: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready not a single cycle after setup");
    AST_NO_READY_IDLE: assert property (!psel |=> !pready)
        else $error("pready without a transfer");
    AST_UNMAPPED: assert property (pready && paddr > 8'h20 |-> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    AST_IPL_RANGE: assert property (cpu_ipl <= 4'h8)
        else $error("priority level out of range");
    AST_IDLE_BEFORE_RUN: assert property (!run_seen_r |-> !x_rd && !x_wr && !y_rd)
        else $error("memory access before run");
    AST_STAT_WIDTH: assert property (rd_done && paddr == `A_STAT |-> prdata[31:23] == 9'h000)
        else $error("program counter wider than 23 bits");
    AST_TRAP_RSV: assert property (rd_done && paddr == `A_TRAP |->
        prdata[31:16] == 16'h0000 && !prdata[5] && prdata[3:1] == 3'h0)
        else $error("trap register reserved bits set");
    AST_IPC_READBACK: assert property (rd_done && paddr == `A_INTERRUPT_PRIORITY_CONTROL_0 |-> prdata == {16'h0000, ipc_r})
        else $error("priority register read-back wrong");
    AST_PAGE_WIDTH: assert property (rd_done && paddr == `A_PAGE |-> prdata[31:8] == 24'h00_0000)
        else $error("page register wider than 8 bits");
    AST_WORD_ALIGN: assert property ((x_rd || x_wr) |-> !x_addr[0] && (!y_rd || !y_addr[0]))
        else $error("data access not word aligned");
endmodule
bind dspc_core dspc_core_sva u_sva (.clock(clock), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .prog_addr(prog_addr), .prog_rdata(prog_rdata),
    .x_addr(x_addr), .x_rd(x_rd), .x_wr(x_wr), .x_wdata(x_wdata), .x_rdata(x_rdata),
    .y_addr(y_addr), .y_rd(y_rd), .y_rdata(y_rdata), .irq(irq), .cpu_ipl(cpu_ipl));

// ### verification/dspc_mem_model.sv
// Program flash and X/Y data memory model at the far side of the core.
`timescale 1ns/100ps
module dspc_mem_model (
    // Clock.
    input wire clock,
    // Program memory, read without delay.
    input wire [22:0] prog_addr,
    output wire [23:0] prog_rdata,
    // Data memory, X read and write, Y read.
    input wire [15:0] x_addr,
    input wire x_rd,
    input wire x_wr,
    input wire [15:0] x_wdata,
    output wire [15:0] x_rdata,
    input wire [15:0] y_addr,
    input wire y_rd,
    output wire [15:0] y_rdata
);
    logic [23:0] prog [0:255];
    logic [15:0] dmem [0:255];
    logic [15:0] junk_r = 16'h5A5A;
    // The program counter counts whole instruction words.
    assign prog_rdata = prog[prog_addr[7:0]];
    // Outside a read strobe the data lines wander, so a late sample cannot pass.
    assign x_rdata = x_rd ? dmem[x_addr[8:1]] : junk_r;
    assign y_rdata = y_rd ? dmem[y_addr[8:1]] : ~junk_r;
    always @(posedge clock) begin
        junk_r <= junk_r + 16'h3C71;
        if (x_wr)
            dmem[x_addr[8:1]] <= x_wdata;
    end
endmodule

// ### verification/testbench.sv
// Self-checking bench for the DSP core: registers over APB and a short program.
`timescale 1ns/100ps
`include "dspc_consts.vh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
    $display("Error at %0t: got %h expected %h", $time, a, b); end end
module testbench;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] irq = 4'h0;
    wire [31:0] prdata;
    wire pready, pslverr, x_rd, x_wr, y_rd;
    wire [22:0] prog_addr;
    wire [23:0] prog_rdata;
    wire [15:0] x_addr, x_wdata, x_rdata, y_addr, y_rdata;
    wire [3:0] cpu_ipl;
    logic [31:0] rdat;
    logic rerr;
    logic [31:0] wq[$];
    int error_cnt = 0;
    int n_compared = 0;
    int cyc = 0;
    always #2 clock = ~clock;
    dspc_core dut (.clock(clock), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .prog_addr(prog_addr), .prog_rdata(prog_rdata), .x_addr(x_addr),
        .x_rd(x_rd), .x_wr(x_wr), .x_wdata(x_wdata), .x_rdata(x_rdata), .y_addr(y_addr),
        .y_rd(y_rd), .y_rdata(y_rdata), .irq(irq), .cpu_ipl(cpu_ipl));
    dspc_mem_model mem (.clock(clock), .prog_addr(prog_addr), .prog_rdata(prog_rdata),
        .x_addr(x_addr), .x_rd(x_rd), .x_wr(x_wr), .x_wdata(x_wdata), .x_rdata(x_rdata),
        .y_addr(y_addr), .y_rd(y_rd), .y_rdata(y_rdata));
    task results;
        $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // One APB transfer; waits for pready and takes the answer at that edge.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        // Only the bench watchdog ends a wait that never sees pready.
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(rdat, exp)
        `CHK(rerr, 1'b0)
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        `CHK(rerr, 1'b0)
    endtask
    always @(posedge clock) begin
        if (x_wr === 1'b1)
            wq.push_back({x_addr, x_wdata});
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            results();
        end
    end
    initial begin
        int n;
        for (int i = 0; i < 256; i++)
            mem.prog[i] = 24'h00_0000;
        mem.prog[0] = 24'h21_1234;
        mem.prog[1] = 24'h22_0100;
        mem.prog[2] = 24'h40_2100;
        mem.prog[3] = 24'h22_0100;
        mem.prog[4] = 24'h33_2000;
        mem.prog[5] = 24'h14_3100;
        mem.prog[6] = 24'h25_0200;
        mem.prog[7] = 24'h40_5400;
        mem.prog[8] = 24'h80_0000;
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        rd(`A_TRAP, 32'h0000_0000);
        rd(`A_INTERRUPT_PRIORITY_CONTROL_0, 32'h0000_4444);
        rd(`A_PAGE, 32'h0000_0000);
        rd(`A_STAT, 32'h0000_0000);
        $display("test reset_values done");
        apb(1'b0, 8'h24, 32'h0000_0000);
        `CHK({rerr, rdat}, {1'b1, 32'h0000_0000})
        apb(1'b1, 8'h24, 32'hFFFF_FFFF);
        `CHK(rerr, 1'b1)
        $display("test unmapped done");
        // Every priority code, including the one that disables a source.
        for (int p = 0; p < 8; p++) begin
            wr(`A_INTERRUPT_PRIORITY_CONTROL_0, {4{1'b1, p[2:0]}});
            rd(`A_INTERRUPT_PRIORITY_CONTROL_0, {16'h0000, {4{1'b0, p[2:0]}}});
        end
        wr(`A_PAGE, 32'h0000_01A5);
        rd(`A_PAGE, 32'h0000_00A5);
        wr(`A_TRAP, 32'hFFFF_FFFF);
        rd(`A_TRAP, 32'h0000_8700);
        wr(`A_TRAP, 32'h0000_0000);
        rd(`A_TRAP, 32'h0000_0000);
        wr(`A_STAT, 32'h0000_1234);
        rd(`A_STAT, 32'h0000_0000);
        $display("test registers done");
        wr(`A_CTRL, 32'h0000_0001);
        n = 0;
        while (wq.size() < 2 && n < 200) begin
            @(posedge clock);
            n++;
        end
        repeat (20) @(posedge clock);
        `CHK(wq.size(), 2)
        `CHK(wq[0], 32'h0100_1234)
        `CHK(wq[1], 32'h0200_2468)
        `CHK(mem.dmem[8'h80], 16'h1234)
        $display("test program done");
        // Source 0 holds priority 7 from the register test; entry pushes two words.
        irq <= 4'h1;
        n = 0;
        while (wq.size() < 4 && n < 200) begin
            @(posedge clock);
            n++;
        end
        `CHK(wq[2], 32'h0800_0000)
        `CHK(wq[3], 32'h0802_0008)
        `CHK(cpu_ipl, 4'h7)
        $display("test interrupt done");
        results();
    end
endmodule
